// file: include/bfpc_defines.svh
`ifndef BFPC_DEFINES_SVH
`define BFPC_DEFINES_SVH

// ==========================================================================
// register offsets
`define BFPC_ADDR_FAULT_SD    8'h3A
`define BFPC_ADDR_BIAS        8'h3B
`define BFPC_ADDR_CH1_CFG     8'h3C

// ==========================================================================
// reset values
`define BFPC_RST_FAULT_SD     8'h10
`define BFPC_RST_BIAS         8'hD0
`define BFPC_RST_CH1_CFG      8'h10
`define BFPC_RST_RDATA        8'h00
`define BFPC_RST_POWERDOWN    1'b0
`define BFPC_RST_CODE_OK      1'b1

// ==========================================================================
// writable bit masks (read-only reserved bits hold zero)
`define BFPC_WMASK_FAULT_SD   8'hF8
`define BFPC_WMASK_BIAS       8'hF3
`define BFPC_WMASK_CH1_CFG    8'hFF

// ==========================================================================
// readback of offsets outside the bank
`define BFPC_UNMAPPED_RDATA   8'h00

// ==========================================================================
// fault policy codes and bias code limits
`define BFPC_POLICY_A         2'h1
`define BFPC_POLICY_B         2'h2
`define BFPC_BIAS_CODE_MIN    4'h7

`endif

// file: include/bfpc_pkg.sv
package bfpc_pkg;

    // ======================================================================
    // fault shutdown register layout
    typedef struct packed {
        logic       sd_a;
        logic       sd_b;
        logic       sd_c;
        logic       sd_d;
        logic       rsvd_rw;
        logic [2:0] rsvd_ro;
    } bfpc_fault_sd_t;

    // ======================================================================
    // bias register layout
    typedef struct packed {
        logic [3:0] bias_voltage_code;
        logic [1:0] rsvd_ro;
        logic [1:0] rsvd_rw;
    } bfpc_bias_t;

    // ======================================================================
    // channel 1 input configuration layout
    typedef struct packed {
        logic       chan1_input_type;
        logic [1:0] chan1_input_source;
        logic       chan1_coupling;
        logic       chan1_swing_range;
        logic [1:0] chan1_amp_mode;
        logic       chan1_autogain_enable;
    } bfpc_ch1_t;

    // ======================================================================
    // fault detector inputs, one level each
    typedef struct packed {
        logic low_current;
        logic high_current;
        logic over_voltage;
        logic over_temp;
    } bfpc_faults_t;

    // ======================================================================
    // complete module state
    typedef struct packed {
        bfpc_fault_sd_t fault_sd;
        bfpc_bias_t     bias;
        bfpc_ch1_t      ch1;
        logic [7:0]     rdata;
        logic           powerdown;
        logic           bias_code_ok;
    } bfpc_state_t;

endpackage

// file: src/bfpc_regs.sv
// Behaviour
// - bit a: low current/high current powers down
// - bit b: over voltage/low current powers down
// - bit c: over temperature/over voltage powers down
// - bit d: high current/over temperature powers down
// - fault shutdown register resets to 0x10
// - bias code 7..15 gives 5..9 V
// - bias register resets to 0xD0
// - channel 1 config layout, resets 0x10
// - coupling bit: 0 AC, 1 DC
`timescale 1ns/1ns
`include "bfpc_defines.svh"

module bfpc_regs
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic [1:0]            fault_policy_select,
    input  wire bfpc_pkg::bfpc_faults_t faults,
    output logic                       powerdown,
    output logic      [3:0]            bias_voltage_code,
    output logic                       bias_code_valid,
    output bfpc_pkg::bfpc_ch1_t        chan1_cfg,
    output logic                       chan1_dc_coupled
);
    import bfpc_pkg::*;

    // ======================================================================
    // state and helpers
    bfpc_state_t st_reg;   // every flop of the bank
    bfpc_state_t st_next;  // value for the next edge
    logic        trip;     // shutdown asked by present faults

    // ======================================================================
    // fault to shutdown mapping per policy
    // the policy only reorders which fault each enable bit guards; a
    // policy code outside the two known ones maps nothing, so a stray
    // value never drops the bias on its own
    function automatic logic shutdown_trip(
        input bfpc_fault_sd_t sd,
        input logic [1:0]     pol,
        input bfpc_faults_t   f
    );
        logic t;
        t = 1'b0;
        case (pol)
            `BFPC_POLICY_A:
            begin
                t = t | (sd.sd_a & f.low_current);
                t = t | (sd.sd_b & f.over_voltage);
                t = t | (sd.sd_c & f.over_temp);
                t = t | (sd.sd_d & f.high_current);
            end
            `BFPC_POLICY_B:
            begin
                t = t | (sd.sd_a & f.high_current);
                t = t | (sd.sd_b & f.low_current);
                t = t | (sd.sd_c & f.over_voltage);
                t = t | (sd.sd_d & f.over_temp);
            end
            default:
            begin
                t = 1'b0;
            end
        endcase
        return t;
    endfunction

    // ======================================================================
    // write merge
    // read-only bits leave the mask as zero, so a careless write can
    // never make them read back as ones
    function automatic logic [7:0] masked_write(
        input logic [7:0] data,
        input logic [7:0] mask
    );
        return data & mask;
    endfunction

    // ======================================================================
    // bias code check
    // codes below seven are stored as written; the bias generator has to
    // hold off by itself while this flag is low
    function automatic logic bias_code_usable(
        input logic [3:0] code
    );
        return code >= `BFPC_BIAS_CODE_MIN;
    endfunction

    // ======================================================================
    // readback multiplexer
    // unmapped offsets read as zero rather than echoing a neighbour
    function automatic logic [7:0] readback(
        input bfpc_state_t s,
        input logic [7:0]  addr
    );
        logic [7:0] r;
        r = `BFPC_UNMAPPED_RDATA;
        case (addr)
            `BFPC_ADDR_FAULT_SD: r = s.fault_sd;
            `BFPC_ADDR_BIAS:     r = s.bias;
            `BFPC_ADDR_CH1_CFG:  r = s.ch1;
            default:             r = `BFPC_UNMAPPED_RDATA;
        endcase
        return r;
    endfunction

    // ======================================================================
    // next state
    // the trip is a level, not a latch: once the fault clears the bias
    // returns by itself, and latching is left to the status registers
    always_comb
    begin
        st_next = st_reg;
        // a one-cycle fault still gives a one-cycle powerdown
        trip = shutdown_trip(st_reg.fault_sd, fault_policy_select, faults);
        st_next.powerdown = trip;

        // register writes; unmapped offsets are ignored
        if (reg_wr)
        begin
            case (reg_addr)
                `BFPC_ADDR_FAULT_SD:
                begin
                    st_next.fault_sd = masked_write(reg_wdata,
                        `BFPC_WMASK_FAULT_SD);
                end
                `BFPC_ADDR_BIAS:
                begin
                    st_next.bias = masked_write(reg_wdata,
                        `BFPC_WMASK_BIAS);
                end
                `BFPC_ADDR_CH1_CFG:
                begin
                    st_next.ch1 = masked_write(reg_wdata,
                        `BFPC_WMASK_CH1_CFG);
                end
                // unmapped write leaves the bank alone
                default:
                begin
                    st_next.ch1 = st_reg.ch1;
                end
            endcase
        end

        st_next.bias_code_ok =
            bias_code_usable(st_next.bias.bias_voltage_code);

        // readback; a read beside a write returns the old contents
        if (reg_rd)
        begin
            st_next.rdata = readback(st_reg, reg_addr);
        end
    end

    // ======================================================================
    // state register
    // only constants in the reset branch; bit d comes up set so high current (policy A)
    // or over temperature (policy B) protection is live before software writes anything
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg.fault_sd     <= `BFPC_RST_FAULT_SD;
            st_reg.bias         <= `BFPC_RST_BIAS;
            st_reg.ch1          <= `BFPC_RST_CH1_CFG;
            st_reg.rdata        <= `BFPC_RST_RDATA;
            st_reg.powerdown    <= `BFPC_RST_POWERDOWN;
            st_reg.bias_code_ok <= `BFPC_RST_CODE_OK;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ======================================================================
    // bus side outputs
    // read data stands until the next read strobe
    assign reg_rdata         = st_reg.rdata;

    // ======================================================================
    // analog side outputs
    // powerdown is registered, so it trails the fault by one cycle
    assign powerdown         = st_reg.powerdown;
    assign bias_voltage_code = st_reg.bias.bias_voltage_code;
    // flag from a flop
    // a flop rather than a compare, so the flag cannot glitch
    assign bias_code_valid   = st_reg.bias_code_ok;

    // ======================================================================
    // channel 1 outputs
    // decoded here so the input stage need not know the bit layout
    assign chan1_cfg         = st_reg.ch1;
    assign chan1_dc_coupled  = st_reg.ch1.chan1_coupling;

endmodule

// file: bench/bfpc_chk.sv
`timescale 1ns/1ns
// ==========================================================
// port checker for the register bank
module bfpc_chk
(
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic [7:0]             reg_rdata,
    input wire logic [1:0]             fault_policy_select,
    input wire bfpc_pkg::bfpc_faults_t faults,
    input wire logic                   powerdown,
    input wire logic [3:0]             bias_voltage_code,
    input wire logic                   bias_code_valid,
    input wire bfpc_pkg::bfpc_ch1_t    chan1_cfg,
    input wire logic                   chan1_dc_coupled
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // one strobe aimed at one address
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    a_policy_gate: assert property (
        fault_policy_select inside {0, 3} |=> !powerdown)
        else $error("powerdown under idle policy");
    a_bias_write: assert property (s_wr(8'h3B) |=>
        bias_voltage_code == $past(reg_wdata[7:4])) else $error("bias code");
    a_code_flag: assert property (
        bias_code_valid == (bias_voltage_code >= 4'h7)) else $error("flag");
    a_ch1_write: assert property (s_wr(8'h3C) |=>
        chan1_cfg == $past(reg_wdata)) else $error("ch1 write");
    a_dc_flag: assert property (s_wr(8'h3C) |=>
        chan1_dc_coupled == $past(reg_wdata[4])) else $error("dc");
    a_quiet_faults: assert property (
        faults == 4'h0 |=> !powerdown) else $error("powerdown no fault");
    a_sd_rsvd: assert property (s_rd(8'h3A) |=>
        reg_rdata[2:0] == 3'h0) else $error("sd reserved bits");
    a_bias_rsvd: assert property (s_rd(8'h3B) |=>
        reg_rdata[3:2] == 2'h0) else $error("bias reserved bits");
    a_ch1_read: assert property (s_rd(8'h3C) |=>
        reg_rdata == $past(chan1_cfg)) else $error("ch1 read");
endmodule

bind bfpc_regs bfpc_chk chk_u (.ref_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .fault_policy_select, .faults,
    .powerdown,
    .bias_voltage_code, .bias_code_valid, .chan1_cfg, .chan1_dc_coupled);

// file: bench/tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// register bank bench
module tb_top;
    import bfpc_pkg::*;
    logic         ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0]   fault_policy_select = 2'h0;
    bfpc_faults_t faults = 4'h0;
    logic         powerdown, bias_code_valid, chan1_dc_coupled;
    logic [3:0]   bias_voltage_code;
    bfpc_ch1_t    chan1_cfg;
    int           errors = 0, checks = 0, cyc = 0;
    bfpc_regs dut_u (.ref_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .fault_policy_select, .faults, .powerdown,
        .bias_voltage_code, .bias_code_valid, .chan1_cfg, .chan1_dc_coupled);
    // free running clock
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    // hang guard, run needs about 150 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            errors++;
            summarize();
        end
    end
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        checks++;
        if (got !== exp)
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        if (got !== exp)
            errors++;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk) #1;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk) #1;
        reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge ref_clk) #1;
        reg_rd = 1;
        reg_addr = a;
        @(posedge ref_clk) #1;
        reg_rd = 0;
        chk(reg_rdata, e);
    endtask
    // reset values, then writes against read-only bits
    task automatic t_regs();
        rd(8'h3A, 8'h10);
        rd(8'h3B, 8'hD0);
        rd(8'h3C, 8'h10);
        chk({3'h0, chan1_dc_coupled, bias_voltage_code}, 8'h1D);
        wr(8'h3A, 8'hFF);
        rd(8'h3A, 8'hF8);
        wr(8'h3B, 8'h6F);
        rd(8'h3B, 8'h63);
        chk({3'h0, bias_code_valid, bias_voltage_code}, 8'h06);
        wr(8'h3B, 8'h7F);
        chk({3'h0, bias_code_valid, bias_voltage_code}, 8'h17);
        wr(8'h3C, 8'hEF);
        rd(8'h3C, 8'hEF);
        chk(chan1_cfg, 8'hEF);
        chk({7'h0, chan1_dc_coupled}, 8'h00);
        wr(8'h3D, 8'h00);
        rd(8'h3C, 8'hEF);
    endtask
    // reset strikes mid-run while powered down, then reset values again
    task automatic t_reset();
        wr(8'h3A, 8'h10);
        fault_policy_select = 2'h2;
        faults = 4'h1;
        wr(8'h3C, 8'h65);
        chk({7'h0, powerdown}, 8'h01);
        @(posedge ref_clk) #1;
        rst = 1;
        @(posedge ref_clk) #1;
        chk(chan1_cfg, 8'h10);
        chk({bias_voltage_code, 4'h0}, 8'hD0);
        chk({7'h0, powerdown}, 8'h00);
        rst = 0;
        rd(8'h3A, 8'h10);
        chk({7'h0, powerdown}, 8'h01);
        faults = 4'h0;
        rd(8'h3C, 8'h10);
        chk({7'h0, powerdown}, 8'h00);
    endtask
    // each enable bit against each fault under all four policies
    task automatic t_faults();
        int   m1[4] = '{3, 1, 0, 2};
        int   m2[4] = '{2, 3, 1, 0};
        logic e;
        for (int p = 0; p < 4; p++)
            for (int b = 0; b < 4; b++)
            begin
                wr(8'h3A, 8'h80 >> b);
                for (int f = 0; f < 4; f++)
                begin
                    fault_policy_select = p[1:0];
                    faults = 4'h1 << f;
                    e = (p == 1 && m1[b] == f) || (p == 2 && m2[b] == f);
                    @(posedge ref_clk) #1;
                    chk({7'h0, powerdown}, {7'h0, e});
                end
            end
    endtask
    task automatic summarize();
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1 rst = 0;
        t_regs();
        t_faults();
        t_reset();
        summarize();
    end
endmodule
